// file: hw/rc_reset_ctrl.sv
// Purpose: Reset controller: classifies requests, drives reset lines.
// Assumes: clock is the clock-out domain; bus and request inputs from the
//          core are on this clock, pins pass a synchroniser first.
// Notes:   Cause flags are read-only; the control register steers sources.
// Notes on behaviour
// RULE1 - Four reset outputs: pin driver, clock module, master, instruction.
// RULE2 - Pin line drives pin, clock reset clock module, master the rest.
// RULE3 - Instruction indication tells circuits the reset instruction ran.
// RULE4 - Each request class asserts its own subset of the reset lines.
// RULE5 - Resets act on clock-out edges; asynchronous ones assert at once.
// RULE6 - Synchronous requests wait until the current bus cycle finishes.
// RULE7 - Waiting lets byte and aligned-word writes on the module bus complete.
// RULE8 - Bus monitor is forced on while reset waits for a bus cycle.
// RULE9 - Hung awaited cycle is ended after the programmed monitor timeout.
// RULE10 - External pin request is synchronous and sets the external flag.
// RULE11 - Power-on detection resets asynchronously and sets its flag.
// RULE12 - Watchdog timeout resets asynchronously and sets its flag.
// RULE13 - Enabled halt monitor seeing halt resets asynchronously, flags halt.
// RULE14 - Reset instruction is asynchronous but not a catastrophic failure.
// RULE15 - External device holds the pin low at least 520 cycles.
// RULE16 - Validate reset, latch configuration and boot select before running.
// RULE17 - Boot chip select answers accesses from address zero out of reset.
// RULE18 - Reset vector is the first four words fetched after reset.
// RULE19 - Clock-loss reset is synchronous, needs enable set and disable clear.
// RULE20 - Cause flags update at pin release, may stack, writes ignored.
// RULE21 - After external release drive 512, float 10, latch, retest pin.
// RULE22 - Internal requests drive pin 512 cycles, longer while still active; watchdog and reset instruction do not extend it here.
//
// Design decisions made here: the register offsets and the address-and-strobe port.
`timescale 1ns/1ps
module rc_reset_ctrl
  import rc_pkg::*;
#(
  parameter int unsigned MODE_W     = 2,
  parameter int unsigned BOOT_AW    = 24,
  parameter int unsigned BOOT_BLK_W = 20,
  parameter logic [6:0]  BMT_CYC0   = 7'h3F,
  parameter logic [6:0]  BMT_CYC1   = 7'h1F,
  parameter logic [6:0]  BMT_CYC2   = 7'h0F,
  parameter logic [6:0]  BMT_CYC3   = 7'h07
)
(
  input  wire logic                 clock,
  input  wire logic                 rstn,
  input  wire logic [RC_ADDR_W-1:0] reg_addr,
  input  wire logic [RC_DATA_W-1:0] reg_wdata,
  input  wire logic                 reg_write,
  input  wire logic                 reg_read,
  output logic      [RC_DATA_W-1:0] reg_rdata,
  input  wire logic                 reset_pin_in,
  output logic                      reset_pin_out,
  output logic                      reset_pin_oe,
  input  wire logic                 power_on_detect,
  input  wire logic                 watchdog_timeout,
  input  wire logic                 halt_seen,
  input  wire logic                 clock_loss,
  input  wire logic                 test_request,
  input  wire logic                 reset_instruction,
  input  wire logic [MODE_W-1:0]    mode_select,
  input  wire logic                 bus_cycle_active,
  input  wire logic                 bus_cycle_ack,
  input  wire logic                 bus_read,
  input  wire logic [BOOT_AW-1:0]   bus_addr,
  output logic                      bus_monitor_active,
  output logic                      bus_cycle_abort,
  output logic                      pin_reset_drive,
  output logic                      clock_module_reset,
  output logic                      master_reset,
  output logic                      reset_instruction_indication,
  output logic                      cpu_run,
  output logic                      boot_chip_select,
  output logic                      vector_fetch,
  output logic      [MODE_W-1:0]    boot_config
);

  typedef struct packed {
    rc_state_e          state;
    logic [9:0]         cnt;
    logic [6:0]         bm_cnt;
    logic [2:0]         valid_cnt;
    logic [2:0]         vec_cnt;
    logic [7:0]         pend;
    logic [7:0]         cause;
    logic [6:0]         ctrl;
    rc_lines_s          lines;
    logic               sys_ind;
    logic               ext_req;
    logic               run;
    logic               abort;
    logic               boot_cs;
    logic               boot_en;
    logic [MODE_W-1:0]  cfg;
    logic [RC_DATA_W-1:0] rdata;
  } rc_st_s;

  localparam logic [9:0] ASSERT_LAST  = 10'(RC_ASSERT_CYCLES - 1);
  localparam logic [9:0] RELEASE_LAST = 10'(RC_RELEASE_CYCLES - 1);
  localparam logic [2:0] VALID_LAST   = 3'(RC_PIN_VALID - 1);
  localparam logic [2:0] VEC_WORDS    = 3'(RC_VECTOR_WORDS);

  // Power-on starts the controller in the assert state with its flag
  // pending, so the first pin release reports a power-on cause.
  localparam rc_st_s ST_RESET = '{
    state:     RC_ASSERT,
    cnt:       '0,
    bm_cnt:    '0,
    valid_cnt: '0,
    vec_cnt:   '0,
    pend:      RC_POW_PENDING,
    cause:     RC_CAUSE_RESET,
    ctrl:      RC_CTRL_RESET,
    lines:     '{master: 1'b1, clock: 1'b1, pin: 1'b1},
    sys_ind:   1'b0,
    ext_req:   1'b0,
    run:       1'b0,
    abort:     1'b0,
    boot_cs:   1'b0,
    boot_en:   1'b1,
    cfg:       '0,
    rdata:     '0
  };

  rc_st_s st_r;
  rc_st_s st_nxt;

  logic [1:0] pins_sync;
  logic       pin_low;
  logic       pow_lvl;

  rc_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clock       (clock),
    .rstn        (rstn),
    .async_in    ({reset_pin_in, power_on_detect}),
    .reset_value (2'b10),
    .sync_out    (pins_sync)
  );

  assign pin_low = ~pins_sync[1];
  assign pow_lvl = pins_sync[0];

  logic      halt_req;
  logic      loc_req;
  logic      async_req;
  logic      sync_int_req;
  logic      int_level;
  logic      ext_valid;
  logic [7:0] new_cause;
  rc_lines_s new_lines;
  logic [6:0] bm_limit;

  always_comb
  begin
    halt_req  = halt_seen & st_r.ctrl[RC_CTRL_HME]; // RULE13
    loc_req   = clock_loss & st_r.ctrl[RC_CTRL_CLOCK_LOSS_RESET_ENABLE]
              & ~st_r.ctrl[RC_CTRL_CLOCK_LOSS_DETECT_DISABLE]; // RULE19
    // Asynchronous sources skip the bus-cycle wait entirely.
    async_req = pow_lvl | watchdog_timeout | halt_req
              | reset_instruction; // RULE5
    sync_int_req = loc_req | test_request;
    // Levels that keep the pin driven past the minimum count.
    int_level = pow_lvl | halt_req | loc_req | test_request; // RULE22
    ext_valid = pin_low & ~st_r.lines.pin
              & (st_r.valid_cnt == VALID_LAST);
    new_cause = '0;
    new_cause[RC_CAUSE_POW] = pow_lvl; // RULE11
    new_cause[RC_CAUSE_WD]  = watchdog_timeout; // RULE12
    new_cause[RC_CAUSE_HLT] = halt_req; // RULE13
    new_cause[RC_CAUSE_LOC] = loc_req; // RULE19
    new_cause[RC_CAUSE_SYS] = reset_instruction; // RULE14
    new_cause[RC_CAUSE_TST] = test_request;
    new_cause[RC_CAUSE_EXT] = ext_valid; // RULE10
    // Line subsets per request class.
    new_lines.pin    = |new_cause; // RULE4
    new_lines.master = |(new_cause & 8'hFD); // RULE4
    new_lines.clock  = |(new_cause & 8'hFC); // RULE4
    case (st_r.ctrl[RC_CTRL_BMT +: 2])
      2'h0:    bm_limit = BMT_CYC0;
      2'h1:    bm_limit = BMT_CYC1;
      2'h2:    bm_limit = BMT_CYC2;
      default: bm_limit = BMT_CYC3;
    endcase
  end

  always_comb
  begin
    st_nxt         = st_r;
    st_nxt.abort   = 1'b0;
    st_nxt.boot_cs = 1'b0;
    st_nxt.rdata   = '0;

    // External request must stay low a few cycles to count as valid.
    if (pin_low && !st_r.lines.pin && st_r.state != RC_RELEASE)
    begin
      if (st_r.valid_cnt != VALID_LAST)
        st_nxt.valid_cnt = st_r.valid_cnt + 3'h1; // RULE16
    end
    else
      st_nxt.valid_cnt = '0;

    // Causes seen during a reset stack until the pin is released.
    st_nxt.pend = st_r.pend | new_cause; // RULE20
    if (ext_valid)
      st_nxt.ext_req = 1'b1;

    case (st_r.state)
      RC_RUN:
      begin
        if (async_req)
        begin
          st_nxt.state   = RC_ASSERT; // RULE5
          st_nxt.lines   = new_lines;
          st_nxt.sys_ind = reset_instruction
                         & ~(new_lines.master | new_lines.clock); // RULE3
          st_nxt.cnt     = '0;
          st_nxt.run     = new_lines.master ? 1'b0 : st_r.run; // RULE14
        end
        else if (ext_valid || sync_int_req)
        begin
          st_nxt.state  = RC_SYNC_WAIT; // RULE6
          st_nxt.bm_cnt = '0;
        end
      end
      RC_SYNC_WAIT:
      begin
        // Holding off until the cycle ends keeps byte and aligned-word
        // writes intact; long or misaligned writes may still be cut.
        if (async_req)
        begin
          st_nxt.state = RC_ASSERT; // RULE5
          st_nxt.lines = new_lines;
          st_nxt.cnt   = '0;
          st_nxt.run   = 1'b0;
        end
        else if (!bus_cycle_active || bus_cycle_ack ||
                 st_r.bm_cnt == bm_limit) // RULE7
        begin
          st_nxt.abort = bus_cycle_active & ~bus_cycle_ack
                       & (st_r.bm_cnt == bm_limit); // RULE9
          st_nxt.lines = '{master: 1'b1, clock: ~test_request | loc_req
                         | st_r.ext_req, pin: ~st_r.ext_req}; // RULE4
          st_nxt.run   = 1'b0;
          st_nxt.cnt   = '0;
          st_nxt.state = st_r.ext_req ? RC_EXT_HOLD : RC_ASSERT;
        end
        else
          st_nxt.bm_cnt = st_r.bm_cnt + 7'h01; // RULE9
      end
      RC_EXT_HOLD:
      begin
        // The pin line stays off here so the device's release is seen.
        st_nxt.lines.pin = 1'b0;
        if (!pin_low)
        begin
          st_nxt.lines.pin = 1'b1; // RULE21
          st_nxt.cnt       = '0;
          st_nxt.state     = RC_ASSERT;
        end
      end
      RC_ASSERT:
      begin
        if (async_req || sync_int_req)
        begin
          st_nxt.lines   = st_r.lines | new_lines; // RULE4
          st_nxt.sys_ind = st_r.sys_ind & ~new_lines.master; // RULE3
          st_nxt.run     = st_r.run & ~new_lines.master; // RULE14
        end
        if (st_r.cnt != ASSERT_LAST)
          st_nxt.cnt = st_r.cnt + 10'h001; // RULE22
        else if (!int_level)
        begin
          st_nxt.lines.pin = 1'b0; // RULE21
          st_nxt.cnt       = '0;
          st_nxt.state     = RC_RELEASE;
        end
      end
      RC_RELEASE:
      begin
        if (st_r.cnt != RELEASE_LAST)
          st_nxt.cnt = st_r.cnt + 10'h001; // RULE21
        else
        begin
          st_nxt.cfg = mode_select; // RULE16
          st_nxt.cnt = '0;
          if (pin_low)
          begin
            st_nxt.lines.pin = 1'b1; // RULE21
            st_nxt.pend[RC_CAUSE_EXT] = 1'b1;
            st_nxt.state = RC_ASSERT;
          end
          else
          begin
            st_nxt.cause   = st_r.pend | new_cause; // RULE20
            st_nxt.pend    = '0;
            st_nxt.ext_req = 1'b0;
            st_nxt.lines   = '0;
            st_nxt.sys_ind = 1'b0;
            st_nxt.state   = RC_RUN;
            if (st_r.lines.master)
            begin
              st_nxt.boot_en = 1'b1; // RULE17
              st_nxt.vec_cnt = '0; // RULE18
            end
            st_nxt.run = 1'b1; // RULE16
          end
        end
      end
      default:
      begin
        st_nxt.state = RC_ASSERT;
        st_nxt.cnt   = '0;
        st_nxt.lines = '{master: 1'b1, clock: 1'b1, pin: 1'b1};
      end
    endcase

    // Boot select decodes the block at address zero after each full reset.
    if (st_r.run && bus_cycle_active && st_r.boot_en &&
        bus_addr[BOOT_AW-1:BOOT_BLK_W] ==
        RC_BOOT_BASE[BOOT_AW-1:BOOT_BLK_W])
      st_nxt.boot_cs = 1'b1; // RULE17

    // Count the reset vector words read after a full reset.
    if (st_r.run && bus_cycle_ack && bus_read &&
        st_r.vec_cnt != VEC_WORDS)
      st_nxt.vec_cnt = st_r.vec_cnt + 3'h1; // RULE18

    // Cause flags ignore writes; only control is writable.
    if (reg_write && reg_addr == RC_REG_CTRL)
      st_nxt.ctrl = reg_wdata[6:0]; // RULE20
    if (reg_read)
    begin
      case (reg_addr)
        RC_REG_CAUSE:  st_nxt.rdata = {8'h00, st_r.cause};
        RC_REG_CTRL:   st_nxt.rdata = {9'h000, st_r.ctrl};
        RC_REG_STATUS: st_nxt.rdata = RC_DATA_W'({st_r.cfg, st_r.run,
                                      st_r.sys_ind, st_r.lines,
                                      pin_low, st_r.state});
        default:       st_nxt.rdata = '0;
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
      st_r <= ST_RESET;
    else
      st_r <= st_nxt;
  end

  // Open-drain pin: only ever pulled low.
  assign reset_pin_out    = 1'b0; // RULE2
  assign reset_pin_oe     = st_r.lines.pin; // RULE2
  assign pin_reset_drive  = st_r.lines.pin; // RULE1
  assign clock_module_reset = st_r.lines.clock; // RULE1
  assign master_reset     = st_r.lines.master; // RULE1
  assign reset_instruction_indication = st_r.sys_ind; // RULE3
  // Forcing the monitor avoids a hung cycle blocking reset forever.
  assign bus_monitor_active = st_r.ctrl[RC_CTRL_BME]
                            | (st_r.state == RC_SYNC_WAIT); // RULE8
  assign bus_cycle_abort  = st_r.abort; // RULE9
  assign cpu_run          = st_r.run;
  assign boot_chip_select = st_r.boot_cs;
  assign vector_fetch     = st_r.run & (st_r.vec_cnt != VEC_WORDS); // RULE18
  assign boot_config      = st_r.cfg;
  assign reg_rdata        = st_r.rdata;

endmodule

// file: hw/rc_pkg.sv
// Purpose: Shared constants and carrier types for the reset controller.
// Assumes: Clock runs at 10 MHz; all counts are in clock cycles.
// Notes:   Register offsets are word indices on the plain register port.
package rc_pkg;

  localparam int unsigned RC_ADDR_W = 4;
  localparam int unsigned RC_DATA_W = 16;

  // Register offsets.
  localparam logic [3:0] RC_REG_CAUSE  = 4'h0;
  localparam logic [3:0] RC_REG_CTRL   = 4'h1;
  localparam logic [3:0] RC_REG_STATUS = 4'h2;

  // Cause flag positions.
  localparam int unsigned RC_CAUSE_EXT  = 7;
  localparam int unsigned RC_CAUSE_POW  = 6;
  localparam int unsigned RC_CAUSE_WD   = 5;
  localparam int unsigned RC_CAUSE_HLT  = 4;
  localparam int unsigned RC_CAUSE_LOC  = 2;
  localparam int unsigned RC_CAUSE_SYS  = 1;
  localparam int unsigned RC_CAUSE_TST  = 0;

  // Control field positions.
  localparam int unsigned RC_CTRL_HME   = 0;
  localparam int unsigned RC_CTRL_CLOCK_LOSS_RESET_ENABLE = 1;
  localparam int unsigned RC_CTRL_CLOCK_LOSS_DETECT_DISABLE = 2;
  localparam int unsigned RC_CTRL_BMT   = 4;
  localparam int unsigned RC_CTRL_BME   = 6;

  // Values after reset.
  localparam logic [7:0] RC_CAUSE_RESET = 8'h00;
  localparam logic [7:0] RC_POW_PENDING = 8'h40;
  localparam logic [6:0] RC_CTRL_RESET  = 7'h00;

  // Cycle counts, vector length and boot base.
  localparam int unsigned RC_ASSERT_CYCLES  = 512;
  localparam int unsigned RC_RELEASE_CYCLES = 10;
  localparam int unsigned RC_PIN_VALID      = 4;
  localparam int unsigned RC_VECTOR_WORDS   = 4;
  localparam logic [23:0] RC_BOOT_BASE      = 24'h000000;

  typedef enum logic [2:0] {
    RC_RUN,
    RC_SYNC_WAIT,
    RC_EXT_HOLD,
    RC_ASSERT,
    RC_RELEASE
  } rc_state_e;

  // The reset lines that one request class asserts.
  typedef struct packed {
    logic master;
    logic clock;
    logic pin;
  } rc_lines_s;

endpackage

// file: hw/rc_sync.sv
// Purpose: Two flip-flop synchroniser for levels from outside the clock.
// Assumes: Inputs are slow levels that stay put for several cycles.
// Notes:   Only the second stage may be read by any other logic.
`timescale 1ns/1ps
module rc_sync
  import rc_pkg::*;
#(
  parameter int unsigned WIDTH = 1
)
(
  input  wire logic             clock,
  input  wire logic             rstn,
  input  wire logic [WIDTH-1:0] async_in,
  input  wire logic [WIDTH-1:0] reset_value,
  output logic      [WIDTH-1:0] sync_out
);

  logic [WIDTH-1:0] stage1_r;

  // Reset value is a port so each instance can pick a safe idle level, but
  // it is applied by a synchronous load after release, never asynchronously.
  logic             loaded_r;

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      stage1_r <= '0;
      sync_out <= '0;
      loaded_r <= 1'b0;
    end
    else
    begin
      loaded_r <= 1'b1;
      stage1_r <= async_in;
      sync_out <= loaded_r ? stage1_r : reset_value;
    end
  end

endmodule

// file: sim/rc_ext_dev.sv
// Purpose: External device that shares the open-drain reset pin.
// Assumes: The pin has a pull-up; this device only ever pulls it low.
// Notes:   Holds the pin for the commanded count, then lets go.
`timescale 1ns/1ps
module rc_ext_dev (
  input  wire logic        clock,
  input  wire logic        go,
  input  wire logic [15:0] hold,
  output logic             pull_low
);
  logic [15:0] cnt_r = 16'h0000;

  always_ff @(posedge clock)
  begin
    if (go)
      cnt_r <= hold;
    else if (cnt_r != 16'h0000)
      cnt_r <= cnt_r - 16'h0001;
  end

  assign pull_low = (cnt_r != 16'h0000);
endmodule

// file: sim/rc_reset_assertions.sv
// Purpose: Port-level checks for the reset controller.
// Assumes: One clock domain; rstn is asynchronous and active low.
// Notes:   Run counters saturate so a long idle spell cannot wrap them.
`timescale 1ns/1ps
module rc_reset_chk
  import rc_pkg::*;
#(
  parameter int unsigned BOOT_AW = 24
)
(
  input wire logic               clock,
  input wire logic               rstn,
  input wire logic               reset_pin_out,
  input wire logic               reset_pin_oe,
  input wire logic               watchdog_timeout,
  input wire logic               test_request,
  input wire logic               bus_cycle_active,
  input wire logic               bus_cycle_ack,
  input wire logic [BOOT_AW-1:0] bus_addr,
  input wire logic               bus_monitor_active,
  input wire logic               bus_cycle_abort,
  input wire logic               pin_reset_drive,
  input wire logic               clock_module_reset,
  input wire logic               master_reset,
  input wire logic               reset_instruction_indication,
  input wire logic               cpu_run,
  input wire logic               boot_chip_select
);
  logic [9:0] on_cnt_r;
  logic [4:0] off_cnt_r;
  logic       boot_hit_r;

  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);

  always_ff @(posedge clock or negedge rstn)
  begin
    if (!rstn)
    begin
      on_cnt_r   <= 10'h000;
      off_cnt_r  <= 5'h00;
      boot_hit_r <= 1'b0;
    end
    else
    begin
      on_cnt_r   <= !reset_pin_oe ? 10'h000 :
                    on_cnt_r + {9'h000, on_cnt_r != 10'h3FF};
      off_cnt_r  <= reset_pin_oe ? 5'h00 :
                    off_cnt_r + {4'h0, off_cnt_r != 5'h1F};
      boot_hit_r <= bus_cycle_active && cpu_run &&
                    bus_addr[BOOT_AW-1 -: 4] == 4'h0;
    end
  end

  a_oe_pulls_low: assert property (
    reset_pin_oe |-> reset_pin_out == 1'b0)
    else $error("pin enabled but not driven low");
  a_clock_needs_master: assert property (
    clock_module_reset |-> master_reset)
    else $error("clock module reset without master reset");
  a_inst_only_pin: assert property (
    reset_instruction_indication |-> !master_reset && !clock_module_reset
      && (!$rose(reset_instruction_indication) || pin_reset_drive)
      && cpu_run)
    else $error("instruction reset touched more than the pin");
  a_wd_immediate: assert property (
    $rose(watchdog_timeout) |-> ##[1:2]
      (master_reset && clock_module_reset && pin_reset_drive))
    else $error("watchdog reset not asserted at once");
  a_sync_holds: assert property (
    $rose(test_request) && bus_cycle_active && !bus_cycle_ack && cpu_run
      && !master_reset |=> !master_reset)
    else $error("synchronous reset cut a bus cycle");
  a_monitor_forced: assert property (
    $rose(test_request) && bus_cycle_active && !bus_cycle_ack && cpu_run
      |-> ##[1:3] bus_monitor_active)
    else $error("bus monitor not forced while waiting");
  a_abort_frees: assert property (
    bus_cycle_abort |-> ##[0:3] master_reset)
    else $error("reset did not follow a monitor abort");
  a_pin_min: assert property (
    $fell(reset_pin_oe) |-> on_cnt_r >= 10'd512)
    else $error("pin driven for fewer than 512 cycles");
  a_float_run: assert property (
    $rose(cpu_run) |-> !reset_pin_oe && off_cnt_r >= 5'd10)
    else $error("run began before the 10 cycle float");
  a_boot_match: assert property (
    boot_chip_select == boot_hit_r)
    else $error("boot select does not follow low addresses");
endmodule

bind rc_reset_ctrl rc_reset_chk #(.BOOT_AW(BOOT_AW)) u_chk (
  .clock(clock), .rstn(rstn), .reset_pin_out(reset_pin_out),
  .reset_pin_oe(reset_pin_oe), .watchdog_timeout(watchdog_timeout),
  .test_request(test_request), .bus_cycle_active(bus_cycle_active),
  .bus_cycle_ack(bus_cycle_ack), .bus_addr(bus_addr),
  .bus_monitor_active(bus_monitor_active),
  .bus_cycle_abort(bus_cycle_abort), .pin_reset_drive(pin_reset_drive),
  .clock_module_reset(clock_module_reset), .master_reset(master_reset),
  .reset_instruction_indication(reset_instruction_indication),
  .cpu_run(cpu_run), .boot_chip_select(boot_chip_select)
);

// file: sim/tb.sv
// Purpose: Self-checking bench for the reset controller.
// Assumes: The reset pin is open drain with a pull-up.
// Notes:   Each reset costs over 520 cycles, so each source runs once.
`timescale 1ns/1ps
module tb;
  import rc_pkg::*;
  logic        clock  = 1'b0;
  logic        rstn   = 1'b0;
  logic [3:0]  addr   = 4'h0;
  logic [15:0] wdata  = 16'h0000;
  logic        wr_s   = 1'b0;
  logic        rd_s   = 1'b0;
  logic        pwr    = 1'b0;
  logic        wd     = 1'b0;
  logic        halt_cause_flag    = 1'b0;
  logic        loss   = 1'b0;
  logic        tst    = 1'b0;
  logic        inst   = 1'b0;
  logic [1:0]  mode   = 2'h0;
  logic        bact   = 1'b0;
  logic        back   = 1'b0;
  logic        bread  = 1'b0;
  logic [23:0] baddr  = 24'h000000;
  logic        ext_go = 1'b0;
  logic [15:0] rdata;
  logic        p_out, p_oe, ext_low, bmon, abort, pdrv, ckr, mst, ind;
  logic        run, bcs, vf;
  logic [1:0]  cfg;
  logic [31:0] seed = 32'h2A81EB60;
  int          bad_count = 0;
  int          cmp_count = 0;
  int          pin_len   = 0;
  // Expected {master, clock, pin} and cause flags: watchdog, halt,
  // power-on, reset instruction.
  logic [2:0]  lines_m [4] = '{3'h7, 3'h7, 3'h7, 3'h1};
  logic [7:0]  cause_m [4] = '{8'h20, 8'h10, 8'h40, 8'h02};
  wire         pin_lvl = !((p_oe && !p_out) || ext_low);

  always #50 clock = ~clock;

  // Length of the current pin drive, so a late start still sees it whole.
  always @(posedge clock)
    pin_len <= (pdrv === 1'b1) ? pin_len + 1 : 0;

  rc_ext_dev ext (.clock(clock), .go(ext_go), .hold(16'h0208),
                  .pull_low(ext_low));
  rc_reset_ctrl dut (
    .clock(clock), .rstn(rstn), .reg_addr(addr), .reg_wdata(wdata),
    .reg_write(wr_s), .reg_read(rd_s), .reg_rdata(rdata),
    .reset_pin_in(pin_lvl), .reset_pin_out(p_out), .reset_pin_oe(p_oe),
    .power_on_detect(pwr), .watchdog_timeout(wd), .halt_seen(halt_cause_flag),
    .clock_loss(loss), .test_request(tst), .reset_instruction(inst),
    .mode_select(mode), .bus_cycle_active(bact), .bus_cycle_ack(back),
    .bus_read(bread), .bus_addr(baddr), .bus_monitor_active(bmon),
    .bus_cycle_abort(abort), .pin_reset_drive(pdrv),
    .clock_module_reset(ckr), .master_reset(mst),
    .reset_instruction_indication(ind), .cpu_run(run),
    .boot_chip_select(bcs), .vector_fetch(vf), .boot_config(cfg));

  function automatic logic [31:0] xs(input logic [31:0] s);
    logic [31:0] v;
    v = s ^ (s << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction

  task automatic chk(input string what, input logic [15:0] seen,
                     input logic [15:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("MISMATCH %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge clock);
    addr  <= a;
    wdata <= d;
    wr_s  <= 1'b1;
    @(posedge clock);
    wr_s  <= 1'b0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [15:0] d);
    @(posedge clock);
    addr <= a;
    rd_s <= 1'b1;
    @(posedge clock);
    rd_s <= 1'b0;
    #1 d = rdata;
  endtask

  task automatic cause_is(input logic [7:0] e);
    logic [15:0] d;
    rd(RC_REG_CAUSE, d);
    chk("cause", d, {8'h00, e});
  endtask

  // Counts pin drive cycles until the processor runs with the pin free.
  task automatic wait_run(output int on);
    int i;
    on = 0;
    for (i = 0; i < 4000; i++)
    begin
      cyc(1);
      if (pdrv === 1'b1)
        on = pin_len + 1;
      else if (run === 1'b1 && mst === 1'b0 && p_oe === 1'b0
               && ind === 1'b0)
        break;
    end
    if (i == 4000)
    begin
      chk("wait_run", 16'h0000, 16'h0001);
      close_out();
    end
  endtask

  initial
  begin
    logic [15:0] d;
    int          on;
    int          k;
    seed = xs(seed);
    mode <= seed[1:0];
    repeat (16) @(posedge clock);
    rstn <= 1'b1;
    wait_run(on);
    chk("pin_on", on >= 512, 1'b1);
    cause_is(8'h40);
    chk("cfg", cfg, mode);
    chk("vec", vf, 1'b1);
    repeat (4)
    begin
      @(posedge clock);
      seed = xs(seed);
      baddr <= {4'h0, seed[19:0]};
      {bact, bread, back} <= 3'h7;
    end
    @(posedge clock);
    {bact, bread, back} <= 3'h0;
    cyc(2);
    chk("vec_done", vf, 1'b0);
    wr(RC_REG_CAUSE, 16'hFFFF);
    cause_is(8'h40);
    rd(4'hF, d);
    chk("unmapped", d, 16'h0000);
    rd(RC_REG_CTRL, d);
    chk("ctrl_rst", d, {9'h000, RC_CTRL_RESET});
    seed = xs(seed);
    wr(RC_REG_CTRL, {9'h000, seed[6:0]});
    rd(RC_REG_CTRL, d);
    chk("ctrl", d, {9'h000, seed[6:0]});
    $display("test boot and registers done");
    // Halt is ignored while its monitor is off.
    wr(RC_REG_CTRL, 16'h0000);
    @(posedge clock);
    halt_cause_flag <= 1'b1;
    cyc(4);
    chk("halt_off", mst, 1'b0);
    @(posedge clock);
    halt_cause_flag <= 1'b0;
    for (k = 0; k < 4; k++)
    begin
      wr(RC_REG_CTRL, 16'h0001);
      @(posedge clock);
      {wd, halt_cause_flag, pwr, inst} <= 4'h8 >> k;
      @(posedge clock);
      {wd, inst} <= 2'h0;
      cyc(4);
      chk("lines", {mst, ckr, pdrv}, lines_m[k]);
      chk("sys_ind", ind, k == 3);
      @(posedge clock);
      {pwr, halt_cause_flag} <= 2'h0;
      wait_run(on);
      chk("pin_on", on >= 512, 1'b1);
      cause_is(cause_m[k]);
      $display("test source %0d done", k);
    end
    @(posedge clock);
    {bact, back, tst} <= 3'h5;
    cyc(3);
    chk("sync_wait", mst, 1'b0);
    chk("mon_on", bmon, 1'b1);
    @(posedge clock);
    back <= 1'b1;
    @(posedge clock);
    {bact, back} <= 2'h0;
    cyc(3);
    chk("tst_lines", {mst, ckr, pdrv}, 3'h5);
    @(posedge clock);
    tst <= 1'b0;
    wait_run(on);
    cause_is(8'h01);
    $display("test synchronous request done");
    wr(RC_REG_CTRL, 16'h0006);
    @(posedge clock);
    loss <= 1'b1;
    cyc(6);
    chk("loss_off", mst, 1'b0);
    @(posedge clock);
    loss <= 1'b0;
    wr(RC_REG_CTRL, 16'h0032);
    @(posedge clock);
    {bact, back, loss} <= 3'h5;
    for (k = 0; k < 20 && abort !== 1'b1; k++)
      cyc(1);
    chk("abort_in", k < 14, 1'b1);
    cyc(3);
    chk("loc_lines", {mst, ckr, pdrv}, 3'h7);
    @(posedge clock);
    {bact, loss} <= 2'h0;
    wait_run(on);
    cause_is(8'h04);
    $display("test clock loss done");
    @(posedge clock);
    ext_go <= 1'b1;
    @(posedge clock);
    ext_go <= 1'b0;
    cyc(20);
    chk("ext_lines", {mst, ckr, p_oe}, 3'h6);
    wait_run(on);
    cause_is(8'h80);
    $display("test external request done");
    close_out();
  end
endmodule
